// file: inc/sct_defs.svh
// Constants of the slow clock seconds timer: offsets, field positions, reset values, timing.
// Assumes it is included by its bare name from the package and design files.
`ifndef SCT_DEFS_SVH
`define SCT_DEFS_SVH

`define SCT_ADDR_W          8
`define SCT_OFS_MODE        8'h00
`define SCT_OFS_ALARM       8'h04
`define SCT_OFS_VALUE       8'h08
`define SCT_OFS_STATUS      8'h0C

`define SCT_MODE_PRES_LSB   0
`define SCT_MODE_PRES_MSB   15
`define SCT_MODE_ALM_IE     16
`define SCT_MODE_INC_IE     17
`define SCT_MODE_RESTART    18

`define SCT_STAT_ALARM      0
`define SCT_STAT_INC        1

`define SCT_RST_MODE        32'h0000_8000
`define SCT_RST_ALARM       32'hFFFF_FFFF
`define SCT_RST_VALUE       32'h0000_0000

`define SCT_CLR_DELAY_TICKS 2'h2

`endif

// file: inc/sct_pkg.sv
// Types shared by the slow clock seconds timer modules.
// Assumes sct_defs.svh is on the include path.
`include "sct_defs.svh"

package sct_pkg;

    typedef struct packed {
        logic [12:0] rsvd;
        logic        restart_divider;
        logic        increment_irq_enable;
        logic        alarm_irq_enable;
        logic [15:0] prescale_value;
    } sct_mode_t;

    typedef struct packed {
        logic increment_flag;
        logic alarm_flag;
    } sct_status_t;

    typedef enum logic [2:0] {
        SCT_REG_MODE   = 3'h0,
        SCT_REG_ALARM  = 3'h1,
        SCT_REG_VALUE  = 3'h2,
        SCT_REG_STATUS = 3'h3,
        SCT_REG_NONE   = 3'h4
    } sct_reg_t;

endpackage

// file: verilog/sct_slow_sync.sv
// Brings the slow clock pin into the system clock domain as a one-cycle tick.
// Assumes the slow clock is far slower than clk_sys, so every edge is seen.
`timescale 1ns/1ps
`default_nettype none

module sct_slow_sync (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic slow_clock,
    output logic      slow_tick
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // Only sync_ff reads meta_ff; the edge detector looks at the second stage.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= slow_clock;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign slow_tick = sync_ff & ~prev_ff;
endmodule

`default_nettype wire

// file: verilog/sct_prescaler.sv
// Programmable divider of slow clock ticks, one period_tick per prescaler period.
// Assumes slow_tick is a single-cycle pulse on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module sct_prescaler (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        slow_tick,
    input  wire logic        restart,
    input  wire logic [15:0] prescale_value,
    output logic             period_tick
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [15:0] last_cnt;
    logic        at_end;

    // A value of zero wraps to the top count, giving a 65536 tick period.
    assign last_cnt    = prescale_value - 16'h0001;
    assign at_end      = (cnt_ff == last_cnt);
    assign period_tick = slow_tick & at_end & ~restart;
    assign nxt_cnt     = restart ? 16'h0000 :
                         (slow_tick ? (at_end ? 16'h0000 : cnt_ff + 16'h0001) : cnt_ff);

    // Restart reloads the divider so a new period starts from the next tick.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

`default_nettype wire

// file: verilog/sct_top.sv
// Slow clock seconds timer: 32-bit counter, alarm, sticky flags and APB register slave.
// Assumes an APB3 master on clk_sys and a free-running slow clock on the slow_clock pin.
`timescale 1ns/1ps
`default_nettype none

`include "sct_defs.svh"

// Function
// - A 32-bit counter advances once per period of a 16-bit slow clock prescaler.
// - Prescaler period equals the prescale value, or 65536 when it is zero.
// - Counter wraps from its maximum to zero and keeps counting.
// - Flags clear two slow clock cycles after a status read; interrupt holds meanwhile.
// - Alarm flag is set when the count matches the alarm register.
// - Alarm register resets to all ones.
// - Increment flag is set every time the counter advances.
// - A status read clears both flags after the two-cycle delay.
// - Writing restart reloads and restarts the prescaler and zeroes the counter.
// - Mode register resets with a prescale value of 0x8000.
// - Prescale in mode bits 15..0, alarm enable 16, increment enable 17, restart 18.
// - Each enabled flag asserts the interrupt; a disabled flag has no effect.
// - Status bit 0 is the alarm flag, bit 1 the increment flag, others zero.
module sct_top
    import sct_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   sys_rst,
    input  wire logic                   slow_clock,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`SCT_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        irq
);

    function automatic sct_reg_t sct_decode(input logic [`SCT_ADDR_W-1:0] addr);
        case (addr)
            `SCT_OFS_MODE:   sct_decode = SCT_REG_MODE;
            `SCT_OFS_ALARM:  sct_decode = SCT_REG_ALARM;
            `SCT_OFS_VALUE:  sct_decode = SCT_REG_VALUE;
            `SCT_OFS_STATUS: sct_decode = SCT_REG_STATUS;
            default:         sct_decode = SCT_REG_NONE;
        endcase
    endfunction

    sct_mode_t   mode_ff;
    sct_mode_t   nxt_mode;
    logic [31:0] alarm_ff;
    logic [31:0] nxt_alarm;
    logic [31:0] count_ff;
    logic [31:0] nxt_count;
    sct_status_t status_ff;
    sct_status_t nxt_status;
    logic        match_ff;
    logic        clr_pend_ff;
    logic        nxt_clr_pend;
    logic [1:0]  clr_ticks_ff;
    logic [1:0]  nxt_clr_ticks;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        slverr_ff;

    logic        slow_tick;
    logic        period_tick;
    sct_reg_t    setup_sel;
    sct_reg_t    access_sel;
    logic        setup_phase;
    logic        access_done;
    logic        wr_mode;
    logic        wr_alarm;
    logic        rd_status;
    logic        restart;
    logic        match_now;
    logic        alarm_event;
    logic        clr_fire;
    sct_mode_t   wr_mode_val;
    logic [31:0] status_word;
    logic [31:0] mode_word;

    sct_slow_sync u_sync (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .slow_clock (slow_clock),
        .slow_tick  (slow_tick)
    );

    sct_prescaler u_pres (
        .clk_sys        (clk_sys),
        .sys_rst        (sys_rst),
        .slow_tick      (slow_tick),
        .restart        (restart),
        .prescale_value (mode_ff.prescale_value),
        .period_tick    (period_tick)
    );

    // The slave never inserts wait states; read data is captured in the setup cycle
    // so that it comes from a flip-flop during the access cycle.
    assign pready      = 1'b1;
    assign pslverr     = slverr_ff;
    assign prdata      = prdata_ff;
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable;
    assign setup_sel   = sct_decode(paddr);
    assign access_sel  = sct_decode(paddr);

    // Value and status registers have no write path.
    assign wr_mode   = access_done & pwrite & (access_sel == SCT_REG_MODE);
    assign wr_alarm  = access_done & pwrite & (access_sel == SCT_REG_ALARM);
    assign rd_status = access_done & ~pwrite & (access_sel == SCT_REG_STATUS);

    assign wr_mode_val = sct_mode_t'(pwdata);
    assign restart     = wr_mode & pwdata[`SCT_MODE_RESTART];

    // Restart is a command, so the stored copy never keeps it set.
    always_comb begin
        nxt_mode = mode_ff;
        if (wr_mode) begin
            nxt_mode.prescale_value       = wr_mode_val.prescale_value;
            nxt_mode.alarm_irq_enable     = pwdata[`SCT_MODE_ALM_IE];
            nxt_mode.increment_irq_enable = pwdata[`SCT_MODE_INC_IE];
        end
        nxt_mode.rsvd            = 13'h0000;
        nxt_mode.restart_divider = 1'b0;
    end

    assign nxt_alarm = wr_alarm ? pwdata : alarm_ff;

    // Counting wraps naturally at the 32-bit width.
    assign nxt_count = restart     ? 32'h0000_0000 :
                       period_tick ? count_ff + 32'h0000_0001 :
                                     count_ff;

    // The flag is set on the cycle the count first equals the alarm, so a held
    // match cannot keep re-arming the flag after software has cleared it.
    assign match_now   = (count_ff == alarm_ff);
    assign alarm_event = match_now & ~match_ff;

    // A status read arms a clear that lands on the second slow clock tick after it.
    // Events in between are folded into the flags and then lost at the clear,
    // which is why small prescale values can drop events.
    assign clr_fire = clr_pend_ff & slow_tick &
                      (clr_ticks_ff == (`SCT_CLR_DELAY_TICKS - 2'h1));

    always_comb begin
        nxt_clr_pend  = clr_pend_ff;
        nxt_clr_ticks = clr_ticks_ff;
        if (rd_status) begin
            nxt_clr_pend  = 1'b1;
            nxt_clr_ticks = 2'h0;
        end else if (clr_fire) begin
            nxt_clr_pend  = 1'b0;
            nxt_clr_ticks = 2'h0;
        end else if (clr_pend_ff & slow_tick) begin
            nxt_clr_ticks = clr_ticks_ff + 2'h1;
        end
    end

    // A new event in the clearing cycle survives the clear.
    always_comb begin
        nxt_status = status_ff;
        if (clr_fire) begin
            nxt_status.alarm_flag     = 1'b0;
            nxt_status.increment_flag = 1'b0;
        end
        if (alarm_event) begin
            nxt_status.alarm_flag = 1'b1;
        end
        if (period_tick) begin
            nxt_status.increment_flag = 1'b1;
        end
    end

    assign status_word = {30'h0000_0000, status_ff.increment_flag,
                          status_ff.alarm_flag};
    assign mode_word   = mode_ff;

    always_comb begin
        case (setup_sel)
            SCT_REG_MODE:   nxt_prdata = mode_word;
            SCT_REG_ALARM:  nxt_prdata = alarm_ff;
            SCT_REG_VALUE:  nxt_prdata = count_ff;
            SCT_REG_STATUS: nxt_prdata = status_word;
            default:        nxt_prdata = 32'h0000_0000;
        endcase
    end

    // Interrupt holds until the delayed clear lands.
    assign irq = (status_ff.alarm_flag & mode_ff.alarm_irq_enable) |
                 (status_ff.increment_flag & mode_ff.increment_irq_enable);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mode_ff  <= sct_mode_t'(`SCT_RST_MODE);
            alarm_ff <= `SCT_RST_ALARM;
            count_ff <= `SCT_RST_VALUE;
        end else begin
            mode_ff  <= nxt_mode;
            alarm_ff <= nxt_alarm;
            count_ff <= nxt_count;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            status_ff    <= '0;
            match_ff     <= 1'b0;
            clr_pend_ff  <= 1'b0;
            clr_ticks_ff <= 2'h0;
        end else begin
            status_ff    <= nxt_status;
            match_ff     <= match_now;
            clr_pend_ff  <= nxt_clr_pend;
            clr_ticks_ff <= nxt_clr_ticks;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
        end else if (setup_phase) begin
            prdata_ff <= nxt_prdata;
            slverr_ff <= (setup_sel == SCT_REG_NONE);
        end
    end

endmodule

`default_nettype wire

// file: test/sct_top_asserts.sv
// Concurrent checks of the seconds timer register port and interrupt output.
// Assumes it is bound to sct_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "sct_defs.svh"
module sct_top_asserts (
    input wire logic                   clk_sys,
    input wire logic                   sys_rst,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`SCT_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [17:0] mode_ff;
    logic [31:0] alarm_ff;
    wire         acc = psel && penable;
    wire         mapped = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);
    // Shadows follow only completed writes, so a dropped write shows up as a readback slip.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mode_ff <= 18'h0_8000;
            alarm_ff <= 32'hFFFF_FFFF;
        end else if (acc && pwrite && paddr == 8'h00) begin
            mode_ff <= pwdata[17:0];
        end else if (acc && pwrite && paddr == 8'h04) begin
            alarm_ff <= pwdata;
        end
    end
    sequence s_rd(logic [7:0] a);
        acc && !pwrite && paddr == a;
    endsequence
    a_ready_in_access: assert property (acc |-> pready)
        else $error("pready low in access cycle");
    a_unmapped_error: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not flagged");
    a_mapped_no_error: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access flagged");
    a_status_upper_zero: assert property (s_rd(8'h0C) |-> prdata[31:2] == 30'h0)
        else $error("status upper bits not zero");
    a_mode_readback: assert property (s_rd(8'h00) |-> prdata == {14'h0, mode_ff})
        else $error("mode readback differs");
    a_alarm_readback: assert property (s_rd(8'h04) |-> prdata == alarm_ff)
        else $error("alarm readback differs");
    a_irq_needs_enable: assert property (irq |-> mode_ff[17:16] != 2'b00)
        else $error("irq without enable");
    a_irq_hold_read: assert property (s_rd(8'h0C) ##0 irq |=> irq[*2])
        else $error("irq dropped right after status read");
endmodule
`default_nettype wire

// file: test/sct_top_tb_top.sv
// Self-checking bench of the seconds timer through its APB port and interrupt.
// Assumes the slow clock is far slower than clk_sys; here it is 16 clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
`include "sct_defs.svh"
module sct_top_tb_top;
    import sct_pkg::*;
    localparam int SLOW = 16;
    logic                   clk_sys = 1'b0;
    logic                   sys_rst = 1'b1;
    logic                   slow_clock = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [`SCT_ADDR_W-1:0] paddr = '0;
    logic [31:0]            pwdata = '0;
    logic [31:0]            prdata;
    logic [31:0]            rd;
    logic                   pready;
    logic                   pslverr;
    logic                   serr;
    logic                   irq;
    sct_mode_t              m;
    int                     err_count = 0;
    int                     n_tests = 0;
    int                     cyc = 0;
    int                     t0;
    int                     slow_cnt = 0;
    always #12.5 clk_sys = ~clk_sys;
    // The slow clock pin is driven off the rising edge so every tick is repeatable.
    always @(posedge clk_sys) begin
        if (slow_cnt == SLOW / 2 - 1) begin
            slow_cnt <= 0;
            slow_clock <= ~slow_clock;
        end else begin
            slow_cnt <= slow_cnt + 1;
        end
    end
    always @(posedge clk_sys) cyc <= cyc + 1;
    sct_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow_clock(slow_clock), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // The count may move between reads, so it is read until two reads agree.
    task automatic rd_value;
        logic [31:0] prev;
        apb(1'b0, `SCT_OFS_VALUE, 32'h0);
        prev = rd;
        apb(1'b0, `SCT_OFS_VALUE, 32'h0);
        while (rd !== prev) begin
            prev = rd;
            apb(1'b0, `SCT_OFS_VALUE, 32'h0);
        end
    endtask
    // Restarts with prescale 0 (a 65536 tick period) and lets the delayed clear land, so no stale flag skews a later check.
    task automatic quiet;
        m = '0;
        m.restart_divider = 1'b1;
        apb(1'b1, `SCT_OFS_MODE, m);
        apb(1'b0, `SCT_OFS_STATUS, 32'h0);
        repeat (3 * SLOW) @(negedge clk_sys);
        apb(1'b0, `SCT_OFS_STATUS, 32'h0);
        chk("status cleared", 32'h0, rd);
    endtask
    // The interrupt is sampled mid-cycle so that it never races the flag registers.
    task automatic wait_irq(input logic lvl);
        @(negedge clk_sys);
        while (irq !== lvl) @(negedge clk_sys);
    endtask
    task automatic inc_period(input logic [15:0] n);
        quiet();
        m = '0;
        m.increment_irq_enable = 1'b1;
        m.restart_divider = 1'b1;
        m.prescale_value = n;
        apb(1'b1, `SCT_OFS_MODE, m);
        wait_irq(1'b1);
        t0 = cyc;
        apb(1'b0, `SCT_OFS_STATUS, 32'h0);
        chk("inc status", 32'h2, rd & 32'h2);
        wait_irq(1'b0);
        chk("irq hold", 32'h1, 32'((cyc - t0) >= SLOW && (cyc - t0) <= 3 * SLOW));
        wait_irq(1'b1);
        chk("period", 32'(n) * SLOW, 32'(cyc - t0));
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        finish_test();
    end
    initial begin
        void'($urandom(46));
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, `SCT_OFS_MODE, 32'h0);
        chk("mode reset", `SCT_RST_MODE, rd);
        apb(1'b0, `SCT_OFS_ALARM, 32'h0);
        chk("alarm reset", `SCT_RST_ALARM, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, 32'(serr));
        apb(1'b1, `SCT_OFS_VALUE, 32'hFFFF_FFFF);
        apb(1'b1, `SCT_OFS_STATUS, 32'h3);
        apb(1'b0, `SCT_OFS_VALUE, 32'h0);
        chk("value ro", 32'h0, rd);
        apb(1'b0, `SCT_OFS_STATUS, 32'h0);
        chk("status ro", 32'h0, rd);
        apb(1'b1, `SCT_OFS_ALARM, $urandom);
        for (int i = 0; i < 4; i++) begin
            inc_period(i == 0 ? 16'h3 : 16'(3 + $urandom % 8));
        end
        quiet();
        apb(1'b1, `SCT_OFS_ALARM, 32'h2);
        m = '0;
        m.alarm_irq_enable = 1'b1;
        m.restart_divider = 1'b1;
        m.prescale_value = 16'h3;
        apb(1'b1, `SCT_OFS_MODE, m);
        rd_value();
        chk("restart value", 32'h0, rd);
        apb(1'b0, `SCT_OFS_STATUS, 32'h0);
        wait_irq(1'b1);
        rd_value();
        chk("alarm value", 32'h2, rd);
        apb(1'b0, `SCT_OFS_STATUS, 32'h0);
        chk("alarm status", 32'h3, rd);
        m.alarm_irq_enable = 1'b0;
        apb(1'b1, `SCT_OFS_MODE, m);
        repeat (8 * SLOW) @(negedge clk_sys);
        chk("masked irq", 32'h0, 32'(irq));
        m.increment_irq_enable = 1'b1;
        m.restart_divider = 1'b0;
        apb(1'b1, `SCT_OFS_MODE, m);
        @(negedge clk_sys);
        chk("unmasked irq", 32'h1, 32'(irq));
        finish_test();
    end
endmodule
bind sct_top sct_top_asserts chk_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
